// File: logic/tics_top.sv
// transmit input clock select, capture and phase-align buffering
`timescale 1ns/1ns
`include "tics_defs.svh"
module tics_top #(
	parameter int NCH = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// static configuration pins
	input wire logic [1:0] tx_clock_source_select,
	input wire logic tx_pll_rate_select,
	input wire logic tx_phase_align_reset_n,
	// clock pins
	input wire logic reference_clock_input,
	input wire logic [NCH-1:0] per_channel_tx_input_clock,
	// character inputs
	input wire logic [NCH*10-1:0] tx_character_input,
	input wire logic [NCH-1:0] tx_odd_parity_input,
	// character stream out, on the reference character rate
	output tics_pkg::tics_char_t [NCH-1:0] out_char,
	output logic [NCH-1:0] out_valid,
	input wire logic [NCH-1:0] out_ready,
	output logic [NCH-1:0] in_stall,
	// status
	output logic [4:0] pll_multiplier,
	output logic phase_locked,
	output logic [1:0] active_source
);
	import tics_pkg::*;

	// two-stage synchronisers for all pins except reset and out_ready
	logic [NCH-1:0] tclk_s1_ff, tclk_s2_ff, tclk_d_ff;
	logic rclk_s1_ff, rclk_s2_ff, rclk_d_ff;
	logic rst_s1_ff, rst_s2_ff, rate_s1_ff, rate_s2_ff;
	logic [1:0] sel_s1_ff, sel_s2_ff;
	tics_char_t [NCH-1:0] din_s1_ff, din_s2_ff;

	// channel clock pins, third flop for edge finding
	always_ff @(posedge mclk) begin
		tclk_s1_ff <= per_channel_tx_input_clock;
		tclk_s2_ff <= tclk_s1_ff;
		tclk_d_ff <= tclk_s2_ff;
	end

	// reference clock pin, third flop for edge finding
	always_ff @(posedge mclk) begin
		rclk_s1_ff <= reference_clock_input;
		rclk_s2_ff <= rclk_s1_ff;
		rclk_d_ff <= rclk_s2_ff;
	end

	// phase-align reset pin
	always_ff @(posedge mclk) begin
		rst_s1_ff <= tx_phase_align_reset_n;
		rst_s2_ff <= rst_s1_ff;
	end

	// rate select pin
	always_ff @(posedge mclk) begin
		rate_s1_ff <= tx_pll_rate_select;
		rate_s2_ff <= rate_s1_ff;
	end

	// clock source select pin
	always_ff @(posedge mclk) begin
		sel_s1_ff <= tx_clock_source_select;
		sel_s2_ff <= sel_s1_ff;
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_din
			always_ff @(posedge mclk) begin
				din_s1_ff[g] <= {tx_odd_parity_input[g], tx_character_input[g*10 +: 10]};
				din_s2_ff[g] <= din_s1_ff[g];
			end
		end
	endgenerate

	// decode of the three-level select
	tics_src_t src;
	always_comb begin
		case (sel_s2_ff)
			`TICS_SEL_LOW: src = TICS_SRC_REF;
			`TICS_SEL_HIGH: src = TICS_SRC_CHA;
			`TICS_SEL_MID: src = TICS_SRC_OWN;
			default: src = TICS_SRC_OWN; // RULE_08
		endcase
	end

	logic ref_rise, ref_fall;
	logic [NCH-1:0] own_rise;
	assign ref_rise = rclk_s2_ff & ~rclk_d_ff;
	assign ref_fall = ~rclk_s2_ff & rclk_d_ff;
	assign own_rise = tclk_s2_ff & ~tclk_d_ff;

	// half rate applies only with reference sourcing
	logic half_rate;
	assign half_rate = rate_s2_ff && (src == TICS_SRC_REF);

	// reference character strobe drives the drain side
	logic char_tick;
	assign char_tick = ref_rise | (half_rate & ref_fall); // RULE_07

	// phase-align reset, ignored when buffer bypassed
	logic bypass, align;
	assign bypass = (src == TICS_SRC_REF) && !rate_s2_ff;
	assign align = !rst_s2_ff && !bypass; // RULE_12 RULE_06

	// per channel capture strobe and two-entry buffer
	logic [NCH-1:0] full_any;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic cap;
			tics_char_t mem_ff [2];
			logic wp_ff, rp_ff;
			logic [1:0] cnt_ff;
			logic push, pop;
			always_comb begin
				case (src)
					TICS_SRC_REF: cap = char_tick; // RULE_10 RULE_04
					TICS_SRC_OWN: cap = own_rise[g]; // RULE_01
					TICS_SRC_CHA: cap = own_rise[0]; // RULE_02
					default: cap = 1'b0;
				endcase
			end
			// no push while full, so nothing is overwritten or duplicated
			assign push = cap && !align && (cnt_ff != 2'h2); // RULE_13
			assign pop = out_valid[g] && out_ready[g];
			// write pointer
			always_ff @(posedge mclk) begin
				if (reset || align) begin
					wp_ff <= 1'b0;
				end else if (push) begin
					wp_ff <= ~wp_ff;
				end
			end

			// storage, contents meaningless until counted
			always_ff @(posedge mclk) begin
				if (push) begin
					mem_ff[wp_ff] <= din_s2_ff[g];
				end
			end

			// read pointer
			always_ff @(posedge mclk) begin
				if (reset || align) begin
					rp_ff <= 1'b0;
				end else if (pop) begin
					rp_ff <= ~rp_ff;
				end
			end

			// occupancy
			always_ff @(posedge mclk) begin
				if (reset || align) begin
					cnt_ff <= 2'h0;
				end else begin
					cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
				end
			end

			// valid rises on a drain strobe, holds while stalled
			always_ff @(posedge mclk) begin
				if (reset || align) begin
					out_valid[g] <= 1'b0;
				end else if (!out_valid[g] || out_ready[g]) begin
					out_valid[g] <= (cnt_ff - {1'b0, pop}) != 2'h0 && char_tick;
				end
			end

			// oldest entry, skipping the one leaving now
			always_ff @(posedge mclk) begin
				if (reset || align) begin
					out_char[g] <= `TICS_RESET_CHAR;
				end else if (!out_valid[g] || out_ready[g]) begin
					out_char[g] <= pop ? mem_ff[~rp_ff] : mem_ff[rp_ff];
				end
			end
			assign full_any[g] = (cnt_ff == 2'h2);
		end
	endgenerate

	// multiplier status
	always_ff @(posedge mclk) begin
		if (reset) begin
			pll_multiplier <= `TICS_MULT_LOW;
		end else begin
			pll_multiplier <= rate_s2_ff ? `TICS_MULT_HIGH : `TICS_MULT_LOW; // RULE_09
		end
	end

	// lock status, high whenever not aligning
	always_ff @(posedge mclk) begin
		if (reset) begin
			phase_locked <= 1'b0;
		end else begin
			phase_locked <= !align; // RULE_06
		end
	end

	// decoded source status
	always_ff @(posedge mclk) begin
		if (reset) begin
			active_source <= 2'h0;
		end else begin
			active_source <= src;
		end
	end

	// buffer full status, registered one cycle behind the full count that drops captures
	always_ff @(posedge mclk) begin
		if (reset) begin
			in_stall <= '0;
		end else begin
			in_stall <= full_any;
		end
	end
endmodule

// File: logic/tics_defs.svh
// constants for the transmit input clock select block
// Functional notes
// [RULE_01] mid select: own clock captures character
// [RULE_02] high select: channel A clock for all
// [RULE_03] host avoids mid/high with half rate
// [RULE_04] low select ignores per-channel clocks
// [RULE_05] host input clocks match reference frequency
// [RULE_06] phase adjusts while reset low, else fixed
// [RULE_07] half rate samples both reference edges
// [RULE_08] floating select reads as middle level
// [RULE_09] pll multiplier twenty high, ten low
// [RULE_10] low select: reference clock captures all
// [RULE_11] host holds phase reset low two edges
// [RULE_12] phase reset ignored when both selects low
// [RULE_13] phase buffer neither drops nor duplicates; code drops captures while the buffer is full
`ifndef TICS_DEFS_SVH
`define TICS_DEFS_SVH
`define TICS_SEL_LOW 2'h0
`define TICS_SEL_MID 2'h1
`define TICS_SEL_HIGH 2'h2
`define TICS_SEL_FLOAT 2'h3
`define TICS_MULT_HIGH 5'h14
`define TICS_MULT_LOW 5'h0a
`define TICS_RESET_CHAR 11'h000
`endif

// File: logic/tics_pkg.sv
// types for the transmit input clock select block
package tics_pkg;
	typedef struct packed {
		logic parity;
		logic [9:0] data;
	} tics_char_t;
	typedef enum logic [1:0] {
		TICS_SRC_REF,
		TICS_SRC_OWN,
		TICS_SRC_CHA
	} tics_src_t;
endpackage

// File: testbench/tics_monitor.sv
// assertions on the tics_top ports
`timescale 1ns/1ns
module tics_monitor #(parameter int NCH = 4) (
	input wire logic mclk, reset, tx_pll_rate_select, tx_phase_align_reset_n,
	input wire logic [1:0] tx_clock_source_select, active_source,
	input wire logic [NCH-1:0] out_valid, out_ready,
	input wire logic [4:0] pll_multiplier,
	input wire tics_pkg::tics_char_t [NCH-1:0] out_char
);
	wire logic [1:0] s = tx_clock_source_select;
	wire logic [1:0] a = active_source;
	wire logic r = tx_pll_rate_select;
	wire logic h = out_valid[0] && !out_ready[0] && tx_phase_align_reset_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	mult_hi_a: assert property (r[*8] |-> pll_multiplier == 5'h14) else $error("mult");
	mult_lo_a: assert property ((!r)[*8] |-> pll_multiplier == 5'h0a) else $error("mult");
	src_ref_a: assert property ((s == 2'h0)[*8] |-> a == 2'h0) else $error("src");
	src_own_a: assert property ((s == 2'h1)[*8] |-> a == 2'h1) else $error("src");
	src_cha_a: assert property ((s == 2'h2)[*8] |-> a == 2'h2) else $error("src");
	src_float_a: assert property ((s == 2'h3)[*8] |-> a == 2'h1) else $error("src");
	valid_hold_a: assert property (h |=> out_valid[0]) else $error("valid");
	char_hold_a: assert property (h |=> $stable(out_char[0])) else $error("char");
	cover property (h);
	cover property (a == 2'h2);
	cover property (pll_multiplier == 5'h14);
endmodule
bind tics_top tics_monitor #(.NCH(NCH)) mon (.*);

// File: testbench/tics_host_model.sv
// host model driving reference, channel clocks and characters
`timescale 1ns/1ns
module tics_host_model (
	output logic reference_clock_input = 1'b0,
	output logic [3:0] per_channel_tx_input_clock, tx_odd_parity_input,
	output logic [39:0] tx_character_input
);
	logic [7:0] cnt = 8'h00;
	always #160 reference_clock_input = ~reference_clock_input;
	assign #15 per_channel_tx_input_clock = {4{reference_clock_input}};
	// new character midway between any two reference edges
	always @(reference_clock_input) cnt <= #80 cnt + 8'h01;
	assign tx_character_input = {cnt, 2'h3, cnt, 2'h2, cnt, 2'h1, cnt, 2'h0};
	assign tx_odd_parity_input = {4{~^cnt}} ^ 4'h6;
endmodule

// File: testbench/test_tics_top.sv
// self-checking bench for tics_top
`timescale 1ns/1ns
module test_tics_top;
	logic mclk = 1'b0, reset = 1'b1, tx_pll_rate_select = 1'b0, tx_phase_align_reset_n = 1'b1;
	logic [1:0] tx_clock_source_select = 2'h0, active_source;
	logic [3:0] out_ready = 4'hf, out_valid, in_stall, tx_odd_parity_input;
	logic [3:0] per_channel_tx_input_clock;
	logic [39:0] tx_character_input;
	logic [4:0] pll_multiplier;
	logic reference_clock_input, phase_locked;
	tics_pkg::tics_char_t [3:0] out_char;
	int fails = 0, check_count = 0, cyc = 0;
	always #20 mclk = ~mclk;
	tics_host_model host (.*);
	tics_top dut (.*);
	always @(posedge mclk) if (++cyc == 3000 && ++fails > 0) results;
	task chk(input logic [10:0] g, input logic [10:0] e);
		check_count++;
		if (g !== e) $display("ERROR %0t got %h exp %h", $time, g, e);
		fails += (g !== e);
	endtask
	task results;
		$display("fails %0d check_count %0d", fails, check_count);
		if (fails == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task run(input logic [1:0] s, input logic r, input logic [4:0] m, input logic [1:0] e);
		logic [7:0] p;
		logic [7:0] st;
		st = r ? 8'h01 : 8'h02;
		tx_clock_source_select = s;
		tx_pll_rate_select = r;
		tx_phase_align_reset_n = 1'b0;
		repeat (40) @(negedge mclk);
		chk({10'h0, phase_locked}, {10'h0, (s == 2'h0) && !r});
		tx_phase_align_reset_n = (s != 2'h0) || r;
		for (int k = 0; k < 6; k++) begin
			@(negedge mclk iff out_valid[0]);
			if (k > 0) chk(out_char[0], {~^{p + st, 2'h0}, p + st, 2'h0});
			p = out_char[0].data[9:2];
		end
		chk({3'h0, phase_locked, pll_multiplier, active_source}, {3'h0, 1'b1, m, e});
	endtask
	initial begin
		repeat (3) @(negedge mclk);
		reset = 1'b0;
		run(2'h0, 1'b0, 5'h0a, 2'h0);
		run(2'h1, 1'b0, 5'h0a, 2'h1);
		run(2'h2, 1'b0, 5'h0a, 2'h2);
		run(2'h3, 1'b0, 5'h0a, 2'h1);
		out_ready = 4'h0;
		repeat (200) @(negedge mclk);
		chk({9'h0, in_stall[0], out_valid[0]}, 11'h3);
		out_ready = 4'hf;
		run(2'h0, 1'b1, 5'h14, 2'h0);
		results;
	end
endmodule
